/* pkg/gll_consts.svh */
`ifndef GLL_CONSTS_SVH
`define GLL_CONSTS_SVH
// Register byte offsets.
`define GLL_OFS_CTRL 8'h00
`define GLL_OFS_CMD 8'h04
`define GLL_OFS_LEARN 8'h08
`define GLL_OFS_RA_STEP 8'h0C
`define GLL_OFS_SCALE 8'h10
`define GLL_OFS_DV_BND 8'h14
`define GLL_OFS_DV_STEP 8'h18
`define GLL_OFS_QMAX 8'h1C
`define GLL_OFS_CONV 8'h20
`define GLL_OFS_CONV_SOC 8'h24
`define GLL_OFS_AVG_I 8'h28
`define GLL_OFS_AVG_P 8'h2C
`define GLL_OFS_DROP 8'h30
`define GLL_OFS_RES_VI 8'h34
`define GLL_OFS_RES_T 8'h38
`define GLL_OFS_LOG 8'h40
// Control field positions.
`define GLL_CTRL_SOC_FLT 0
`define GLL_CTRL_FAST_CONV 1
`define GLL_CTRL_QUICK_LEARN 2
`define GLL_CTRL_BLK_LSB 8
// Learning-state codes, the tracking-enable subcommand, the sealed log-access block and the capacity-limit divisor.
`define GLL_LEARN_GOLDEN 8'h02
`define GLL_LEARN_NONE 8'h04
`define GLL_LEARN_QMAX 8'h05
`define GLL_LEARN_FULL 8'h06
`define GLL_CMD_TRACK_EN 16'h0021
`define GLL_SEALED_BLOCK 4'h4
`define GLL_QMAX_DIV 32'd100
// Reset values and the clock frequency.
`define GLL_RST_CTRL 4'h3
`define GLL_RST_RA_STEP 16'h0100
`define GLL_RST_SCALE 32'h0300_0040
`define GLL_RST_DV_BND 32'h0200_0000
`define GLL_RST_DV_STEP 16'h0020
`define GLL_RST_QMAX 32'h0014_0BB8
`define GLL_RST_CONV 32'h0064_0BB8
`define GLL_RST_CONV_SOC 8'h0A
`define GLL_RST_RES_VI 32'h0032_0032
`define GLL_RST_RES_T 32'h0000_000A
`define GLL_RST_MAX 16'h8000
`define GLL_RST_MIN 16'h7FFF
`define GLL_CLK_HZ 250000000
`endif

/* pkg/gll_pkg.sv */
package gll_pkg;
   typedef enum logic [1:0] {
      GLL_LOG_IDLE = 2'b00,
      GLL_LOG_WINDOW = 2'b01,
      GLL_LOG_COMMIT = 2'b11
   } gll_log_state_t;
   typedef logic signed [15:0] gll_entry_t;
endpackage : gll_pkg

/* design/gll_gauge_log.sv */
`timescale 1ns/100ps
`include "gll_consts.svh"
module gll_gauge_log import gll_pkg::*; #(
   parameter int SEC_CYCLES = `GLL_CLK_HZ,
   parameter int ENTRIES = 6
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Gauge state.
   input wire logic sealed,
   input wire logic device_reset,
   input wire logic learn_cycle,
   input wire logic learn_qmax_done,
   input wire logic learn_ra_done,
   input wire logic dsg_active,
   // Measurements.
   input wire logic sample_valid,
   input wire logic signed [15:0] volt,
   input wire logic signed [15:0] curr,
   input wire logic signed [15:0] temp,
   input wire logic spike_valid,
   input wire logic [15:0] spike_volt,
   // Resistance and capacity updates.
   input wire logic ra_valid,
   input wire logic [15:0] ra_old,
   input wire logic [15:0] ra_new,
   input wire logic qmax_valid,
   input wire logic qmax_quick_valid,
   input wire logic [15:0] qmax_old,
   input wire logic [15:0] qmax_new,
   // Capacity sources.
   input wire logic [15:0] rm_unf,
   input wire logic [15:0] fcc_unf,
   input wire logic [15:0] rm_flt,
   input wire logic [15:0] fcc_flt,
   // Results.
   output logic [15:0] ra_out,
   output logic ra_out_valid,
   output logic [15:0] qmax_out,
   output logic qmax_out_valid,
   output logic [15:0] rm_out,
   output logic [15:0] full_charge_capacity,
   output logic [7:0] soc_out,
   output logic fast_conv_active,
   output logic nv_write
);
   initial begin
      if (ENTRIES != 6 || SEC_CYCLES < 1) $error("gll_gauge_log: unsupported parameters.");
   end

   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   function automatic logic [31:0] step_clamp(input logic [31:0] v, input logic [31:0] old,
                                              input logic [31:0] step);
      step_clamp = clamp(v, (old > step) ? old - step : 32'h0, old + step);
   endfunction : step_clamp

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [3:0] ctrl_reg;
   logic [3:0] blk_reg;
   logic [15:0] ra_step_reg;
   logic [31:0] scale_reg, dv_bnd_reg, qmax_cfg_reg, conv_reg, res_vi_reg, res_t_reg;
   logic [15:0] dv_step_reg;
   logic [7:0] conv_soc_reg;
   logic [7:0] learn_reg;
   logic signed [31:0] avg_i_reg, avg_p_reg;
   logic [15:0] drop_reg;
   gll_entry_t work_reg [ENTRIES];
   gll_entry_t store_reg [ENTRIES];
   gll_entry_t pend_reg [ENTRIES];
   logic acc, wr_do, log_sel, err_next;
   logic [2:0] log_idx;
   logic [31:0] rd_next;

   assign acc = psel & penable & ~pready;
   assign wr_do = psel & penable & pready & pwrite & ~pslverr;
   assign log_sel = paddr >= `GLL_OFS_LOG && paddr < `GLL_OFS_LOG + 8'(4 * ENTRIES);
   assign log_idx = 3'((paddr - `GLL_OFS_LOG) >> 2);

   always_comb begin
      rd_next = 32'h0;
      err_next = 1'b0;
      case (paddr)
         `GLL_OFS_CTRL: rd_next = {20'h0, blk_reg, 5'h0, ctrl_reg[2:0]};
         `GLL_OFS_CMD: rd_next = 32'h0;
         `GLL_OFS_LEARN: rd_next = {24'h0, learn_reg};
         `GLL_OFS_RA_STEP: rd_next = {16'h0, ra_step_reg};
         `GLL_OFS_SCALE: rd_next = scale_reg;
         `GLL_OFS_DV_BND: rd_next = dv_bnd_reg;
         `GLL_OFS_DV_STEP: rd_next = {16'h0, dv_step_reg};
         `GLL_OFS_QMAX: rd_next = qmax_cfg_reg;
         `GLL_OFS_CONV: rd_next = conv_reg;
         `GLL_OFS_CONV_SOC: rd_next = {24'h0, conv_soc_reg};
         `GLL_OFS_AVG_I: rd_next = avg_i_reg;
         `GLL_OFS_AVG_P: rd_next = avg_p_reg;
         `GLL_OFS_DROP: rd_next = {16'h0, drop_reg};
         `GLL_OFS_RES_VI: begin
            rd_next = res_vi_reg;
            err_next = pwrite & sealed;
         end
         `GLL_OFS_RES_T: begin
            rd_next = res_t_reg;
            err_next = pwrite & sealed;
         end
         default: begin
            if (log_sel) begin
               rd_next = {16'h0, store_reg[log_idx]};
               err_next = sealed & (blk_reg != `GLL_SEALED_BLOCK);
            end else begin
               err_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= acc;
         pslverr <= acc & err_next;
         if (acc && !pwrite) begin
            prdata <= err_next ? 32'h0 : rd_next;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `GLL_RST_CTRL;
         blk_reg <= 4'h0;
         ra_step_reg <= `GLL_RST_RA_STEP;
         scale_reg <= `GLL_RST_SCALE;
         dv_bnd_reg <= `GLL_RST_DV_BND;
         dv_step_reg <= `GLL_RST_DV_STEP;
         qmax_cfg_reg <= `GLL_RST_QMAX;
         conv_reg <= `GLL_RST_CONV;
         conv_soc_reg <= `GLL_RST_CONV_SOC;
         res_vi_reg <= `GLL_RST_RES_VI;
         res_t_reg <= `GLL_RST_RES_T;
         for (int k = 0; k < ENTRIES; k++) pend_reg[k] <= (k % 2 == 0) ? `GLL_RST_MAX : `GLL_RST_MIN;
      end else if (wr_do) begin
         case (paddr)
            `GLL_OFS_CTRL: begin
               ctrl_reg <= {1'b0, pwdata[2:0]};
               blk_reg <= pwdata[`GLL_CTRL_BLK_LSB +: 4];
            end
            `GLL_OFS_RA_STEP: ra_step_reg <= pwdata[15:0];
            `GLL_OFS_SCALE: scale_reg <= pwdata;
            `GLL_OFS_DV_BND: dv_bnd_reg <= pwdata;
            `GLL_OFS_DV_STEP: dv_step_reg <= pwdata[15:0];
            `GLL_OFS_QMAX: qmax_cfg_reg <= pwdata;
            `GLL_OFS_CONV: conv_reg <= pwdata;
            `GLL_OFS_CONV_SOC: conv_soc_reg <= pwdata[7:0];
            `GLL_OFS_RES_VI: res_vi_reg <= pwdata;
            `GLL_OFS_RES_T: res_t_reg <= pwdata;
            default: if (log_sel) pend_reg[log_idx] <= pwdata[15:0];
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Learning state
   // ----------------------------------------------------------------
   logic cmd_en;
   assign cmd_en = wr_do && paddr == `GLL_OFS_CMD && pwdata[15:0] == `GLL_CMD_TRACK_EN;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         learn_reg <= `GLL_LEARN_GOLDEN;
      end else if (cmd_en && learn_reg == `GLL_LEARN_GOLDEN) begin
         learn_reg <= `GLL_LEARN_FULL;
      end else if (learn_cycle && learn_qmax_done && learn_reg == `GLL_LEARN_NONE) begin
         learn_reg <= `GLL_LEARN_QMAX;
      end else if (learn_cycle && learn_ra_done && learn_reg != `GLL_LEARN_GOLDEN) begin
         learn_reg <= `GLL_LEARN_FULL;
      end
   end

   // ----------------------------------------------------------------
   // Discharge-cycle averages and pulse drop
   // ----------------------------------------------------------------
   logic dsg_d_reg;
   logic signed [47:0] sum_i_reg;
   logic signed [63:0] sum_p_reg;
   logic [23:0] cnt_reg;
   logic [15:0] last_v_reg, diff, drop_cand;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dsg_d_reg <= 1'b0;
         sum_i_reg <= '0;
         sum_p_reg <= '0;
         cnt_reg <= '0;
         avg_i_reg <= '0;
         avg_p_reg <= '0;
      end else begin
         dsg_d_reg <= dsg_active;
         if (dsg_active && !dsg_d_reg) begin
            sum_i_reg <= '0;
            sum_p_reg <= '0;
            cnt_reg <= '0;
         end else if (dsg_active && sample_valid) begin
            sum_i_reg <= sum_i_reg + 48'(curr);
            sum_p_reg <= sum_p_reg + 64'(curr) * 64'(volt);
            cnt_reg <= cnt_reg + 24'h1;
         end
         if (!dsg_active && dsg_d_reg && cnt_reg != 24'h0) begin
            avg_i_reg <= 32'(sum_i_reg / $signed({1'b0, cnt_reg}));
            avg_p_reg <= 32'(sum_p_reg / $signed({1'b0, cnt_reg}));
         end
      end
   end

   assign diff = (last_v_reg > spike_volt) ? last_v_reg - spike_volt : 16'h0;
   assign drop_cand = (diff > drop_reg) ? diff : drop_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_v_reg <= 16'h0;
         drop_reg <= 16'h0;
      end else begin
         if (sample_valid) last_v_reg <= volt;
         if (spike_valid) begin
            drop_reg <= 16'(step_clamp(clamp(32'(drop_cand), 32'(dv_bnd_reg[15:0]),
               32'(dv_bnd_reg[31:16])), 32'(drop_reg), 32'(dv_step_reg)));
         end
      end
   end

   // ----------------------------------------------------------------
   // Resistance and capacity limiting
   // ----------------------------------------------------------------
   logic [15:0] ra_base_reg;
   logic ra_base_ok_reg;
   logic [31:0] ra_lo, ra_hi, ra_scaled, q_lim;
   logic q_take;

   assign ra_lo = (32'(ra_base_reg) * 32'(scale_reg[15:0])) >> 8;
   assign ra_hi = (32'(ra_base_reg) * 32'(scale_reg[31:16])) >> 8;
   assign ra_scaled = clamp(32'(ra_new), ra_lo, ra_hi);
   assign q_lim = 32'(qmax_cfg_reg[15:0]) * 32'(qmax_cfg_reg[23:16]) / `GLL_QMAX_DIV;
   assign q_take = qmax_valid | (qmax_quick_valid & ctrl_reg[`GLL_CTRL_QUICK_LEARN] & ~learn_cycle);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ra_base_reg <= 16'h0;
         ra_base_ok_reg <= 1'b0;
         ra_out <= 16'h0;
         ra_out_valid <= 1'b0;
         qmax_out <= 16'h0;
         qmax_out_valid <= 1'b0;
      end else begin
         if (dsg_active && !dsg_d_reg) ra_base_ok_reg <= 1'b0;
         if (ra_valid && !ra_base_ok_reg) begin
            ra_base_reg <= ra_old;
            ra_base_ok_reg <= 1'b1;
         end
         ra_out_valid <= ra_valid & ra_base_ok_reg;
         if (ra_valid && ra_base_ok_reg) begin
            ra_out <= 16'(step_clamp(ra_scaled, 32'(ra_old), 32'(ra_step_reg)));
         end
         qmax_out_valid <= q_take;
         if (q_take) qmax_out <= 16'(step_clamp(32'(qmax_new), 32'(qmax_old), q_lim));
      end
   end

   // ----------------------------------------------------------------
   // Reported capacity and convergence
   // ----------------------------------------------------------------
   logic [15:0] rm_sel, fcc_sel;
   assign rm_sel = ctrl_reg[`GLL_CTRL_SOC_FLT] ? rm_flt : rm_unf;
   assign fcc_sel = ctrl_reg[`GLL_CTRL_SOC_FLT] ? fcc_flt : fcc_unf;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rm_out <= 16'h0;
         full_charge_capacity <= 16'h0;
         soc_out <= 8'h0;
         fast_conv_active <= 1'b0;
      end else begin
         rm_out <= rm_sel;
         full_charge_capacity <= fcc_sel;
         soc_out <= (fcc_sel == 16'h0) ? 8'h0 : 8'(32'(rm_sel) * 32'd100 / 32'(fcc_sel));
         fast_conv_active <= ctrl_reg[`GLL_CTRL_FAST_CONV] &
            ((32'(volt) < 32'(conv_reg[15:0]) + 32'(conv_reg[31:16])) ||
            (soc_out < conv_soc_reg));
      end
   end

   // ----------------------------------------------------------------
   // Lifetime log
   // ----------------------------------------------------------------
   gll_log_state_t log_st_reg;
   logic log_on, any_exceed;
   logic [ENTRIES-1:0] exceed;
   logic [31:0] sec_cnt_reg;
   logic [15:0] win_sec_reg;

   assign log_on = learn_reg != `GLL_LEARN_GOLDEN && res_t_reg[31:16] != 16'h0;
   assign any_exceed = |exceed;

   function automatic gll_entry_t samp_of(input int k);
      samp_of = (k < 2) ? volt : ((k < 4) ? curr : temp);
   endfunction : samp_of

   function automatic logic signed [17:0] res_of(input int k);
      res_of = 18'((k < 2) ? res_vi_reg[15:0] : ((k < 4) ? res_vi_reg[31:16] : res_t_reg[15:0]));
   endfunction : res_of

   for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
      if (g % 2 == 0) begin : g_max
         assign exceed[g] = log_on && sample_valid &&
            18'(samp_of(g)) > 18'(store_reg[g]) + res_of(g);
      end else begin : g_min
         assign exceed[g] = log_on && sample_valid &&
            18'(samp_of(g)) < 18'(store_reg[g]) - res_of(g);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < ENTRIES; k++) work_reg[k] <= (k % 2 == 0) ? `GLL_RST_MAX : `GLL_RST_MIN;
      end else if (device_reset) begin
         work_reg <= pend_reg;
      end else if (log_on && sample_valid) begin
         for (int k = 0; k < ENTRIES; k++) begin
            if ((k % 2 == 0) ? samp_of(k) > work_reg[k] : samp_of(k) < work_reg[k]) begin
               work_reg[k] <= samp_of(k);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         log_st_reg <= GLL_LOG_IDLE;
         sec_cnt_reg <= '0;
         win_sec_reg <= '0;
         nv_write <= 1'b0;
         for (int k = 0; k < ENTRIES; k++) store_reg[k] <= (k % 2 == 0) ? `GLL_RST_MAX : `GLL_RST_MIN;
      end else if (device_reset) begin
         log_st_reg <= GLL_LOG_IDLE;
         nv_write <= 1'b0;
         store_reg <= pend_reg;
      end else begin
         nv_write <= 1'b0;
         case (log_st_reg)
            GLL_LOG_IDLE: begin
               sec_cnt_reg <= '0;
               win_sec_reg <= '0;
               if (any_exceed) log_st_reg <= GLL_LOG_WINDOW;
            end
            GLL_LOG_WINDOW: begin
               if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
                  sec_cnt_reg <= '0;
                  win_sec_reg <= win_sec_reg + 16'h1;
                  if (win_sec_reg + 16'h1 >= res_t_reg[31:16]) log_st_reg <= GLL_LOG_COMMIT;
               end else begin
                  sec_cnt_reg <= sec_cnt_reg + 32'h1;
               end
            end
            GLL_LOG_COMMIT: begin
               store_reg <= work_reg;
               nv_write <= 1'b1;
               log_st_reg <= GLL_LOG_IDLE;
            end
            default: log_st_reg <= GLL_LOG_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_LEARN_CODE: assert property (learn_reg inside {8'h02, 8'h04, 8'h05, 8'h06})
      else $error("Illegal learning state.");
   AST_LEARN_HOLD: assert property ($changed(learn_reg) |-> $past(learn_cycle) || $past(cmd_en))
      else $error("Learning state changed without cause.");
   AST_DROP_BOUNDS: assert property (spike_valid && dv_bnd_reg[15:0] <= drop_reg &&
      drop_reg <= dv_bnd_reg[31:16] && $stable(dv_bnd_reg) |=> drop_reg >= dv_bnd_reg[15:0] ||
      $past(drop_reg) - drop_reg == dv_step_reg)
      else $error("Pulse drop left its bounds.");
   AST_DROP_STEP: assert property (spike_valid |=> 32'(drop_reg) <= 32'($past(drop_reg)) +
      32'($past(dv_step_reg)))
      else $error("Pulse drop stepped too far.");
   AST_RA_STEP: assert property (ra_out_valid |-> 32'(ra_out) <= 32'($past(ra_old)) +
      32'($past(ra_step_reg)))
      else $error("Resistance step too large.");
   AST_QMAX_CLAMP: assert property (q_take |=> 32'(qmax_out) <= 32'($past(qmax_old)) +
      $past(q_lim))
      else $error("Capacity update beyond limit.");
   AST_QUICK_LEARN: assert property (learn_cycle && !qmax_valid |=> !qmax_out_valid)
      else $error("Quick learning during learning cycle.");
   AST_SOC_SEL: assert property (rm_out == ($past(ctrl_reg[0]) ? $past(rm_flt) : $past(rm_unf)))
      else $error("Wrong capacity source.");
   AST_LOG_OFF: assert property (!log_on |-> ##1 $stable(work_reg[0]) || $past(device_reset))
      else $error("Working table moved while logging off.");
   AST_COMMIT_COPY: assert property (log_st_reg == GLL_LOG_COMMIT && !device_reset |=>
      nv_write ##0 store_reg[0] == $past(work_reg[0]))
      else $error("Commit did not copy the table.");
   AST_SEAL_RES: assert property (wr_do && sealed && paddr == `GLL_OFS_RES_T |=>
      $stable(res_t_reg))
      else $error("Sealed write reached resolution settings.");

   COV_COMMIT: cover property (nv_write);
   COV_TRACK_EN: cover property (cmd_en ##1 learn_reg == 8'h06);
   COV_SEAL_ERR: cover property (pready && pslverr);
   COV_RA_CLAMP: cover property (ra_out_valid && ra_out != $past(ra_new));
endmodule : gll_gauge_log

/* tb/gll_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Host processor model, APB master side.
// ----------------------------------------
module gll_host_model (
   // Clock.
   input wire logic pclk,
   // APB master.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic timed_out = 1'b0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      rd = 32'h0;
      err = 1'b1;
      for (n = 0; n < 64; n++) begin
         // Look at the answer at the falling edge, while it is settled, and take it there.
         @(negedge pclk);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            break;
         end
         @(posedge pclk);
      end
      timed_out = (n == 64);
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines show the inverse of the last value; pwrite keeps its last value.
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : gll_host_model

/* tb/gll_gauge_log_test.sv */
`timescale 1ns/100ps
`include "gll_consts.svh"
module gll_gauge_log_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, soc_out;
   logic [31:0] pwdata, prdata, rd;
   logic sealed, device_reset, learn_cycle, learn_qmax_done, learn_ra_done, dsg_active;
   logic sample_valid, spike_valid, ra_valid, qmax_valid, qmax_quick_valid;
   logic signed [15:0] volt, curr, temp;
   logic [15:0] spike_volt, ra_old, ra_new, qmax_old, qmax_new, rm_unf, fcc_unf, rm_flt, fcc_flt;
   logic [15:0] ra_out, qmax_out, rm_out, full_charge_capacity;
   logic ra_out_valid, qmax_out_valid, fast_conv_active, nv_write;
   int mismatches = 0, cmp_count = 0, seed = 34, cnt, i;
   gll_gauge_log #(.SEC_CYCLES(4), .ENTRIES(6)) gll_gauge_log_inst (.*);
   gll_host_model gll_host_model_inst (.*);
   always #2 pclk = ~pclk;
   task finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      gll_host_model_inst.xfer(w, a, d, rd, err);
      if (gll_host_model_inst.timed_out) begin
         mismatches++;
         $display("ERROR %0t: no bus answer", $time);
         finish_test();
      end
   endtask : rw
   task sample_and_count(input int cyc);
      @(posedge pclk);
      sample_valid <= 1'b1;
      volt <= 16'sd1000;
      curr <= 16'sd100;
      temp <= 16'sd250;
      @(posedge pclk);
      sample_valid <= 1'b0;
      cnt = 0;
      repeat (cyc) begin
         @(posedge pclk);
         #1;
         if (nv_write === 1'b1) cnt++;
      end
   endtask : sample_and_count
   function automatic logic [15:0] qclamp(input logic [15:0] o, input logic [15:0] nw);
      logic [31:0] lim;
      lim = (`GLL_RST_QMAX & 32'hFFFF) * ((`GLL_RST_QMAX >> 16) & 32'hFF) / `GLL_QMAX_DIV;
      if (nw > o + lim) return o + lim;
      if (nw + lim < o) return o - lim;
      return nw;
   endfunction : qclamp
   function automatic logic [7:0] soc_exp(input logic [15:0] r, input logic [15:0] f);
      if (f == 16'h0) return 8'h0;
      return 8'(32'(r) * 32'd100 / 32'(f));
   endfunction : soc_exp
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {sealed, device_reset, learn_cycle, learn_qmax_done, learn_ra_done, dsg_active} = '0;
      {sample_valid, spike_valid, ra_valid, qmax_valid, qmax_quick_valid} = '0;
      {volt, curr, temp, spike_volt, ra_old, ra_new, qmax_old, qmax_new} = '0;
      {rm_unf, fcc_unf, rm_flt, fcc_flt} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rw(0, `GLL_OFS_CTRL, 0);
      chk(rd, `GLL_RST_CTRL);
      rw(0, `GLL_OFS_LEARN, 0);
      chk(rd, `GLL_LEARN_GOLDEN);
      rw(0, `GLL_OFS_CONV, 0);
      chk(rd, `GLL_RST_CONV);
      rw(0, 8'h3C, 0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      @(posedge pclk);
      learn_ra_done <= 1'b1;
      @(posedge pclk);
      learn_ra_done <= 1'b0;
      rw(0, `GLL_OFS_LEARN, 0);
      chk(rd, `GLL_LEARN_GOLDEN);
      rw(1, `GLL_OFS_CMD, `GLL_CMD_TRACK_EN);
      rw(0, `GLL_OFS_LEARN, 0);
      chk(rd, `GLL_LEARN_FULL);
      sample_and_count(20);
      chk(cnt, 0);
      rw(1, `GLL_OFS_RES_T, 32'h0001_000A);
      sample_and_count(30);
      chk(cnt, 1);
      rw(0, `GLL_OFS_LOG, 0);
      chk(rd[15:0], 16'd1000);
      rw(0, `GLL_OFS_LOG + 8'h04, 0);
      chk(rd[15:0], 16'd1000);
      rw(0, `GLL_OFS_LOG + 8'h08, 0);
      chk(rd[15:0], 16'd100);
      rw(1, `GLL_OFS_LOG, 32'h0123);
      rw(0, `GLL_OFS_LOG, 0);
      chk(rd[15:0], 16'd1000);
      @(posedge pclk);
      device_reset <= 1'b1;
      @(posedge pclk);
      device_reset <= 1'b0;
      rw(0, `GLL_OFS_LOG, 0);
      chk(rd[15:0], 16'h0123);
      @(posedge pclk);
      sealed <= 1'b1;
      rw(0, `GLL_OFS_LOG, 0);
      chk(err, 1'b1);
      rw(1, `GLL_OFS_CTRL, 32'h0403);
      rw(0, `GLL_OFS_LOG, 0);
      chk({err, rd[15:0]}, 17'h0_0123);
      rw(1, `GLL_OFS_RES_VI, 0);
      chk(err, 1'b1);
      @(posedge pclk);
      sealed <= 1'b0;
      for (i = 0; i < 2; i++) begin
         rw(1, `GLL_OFS_CTRL, 32'h2 | i);
         rm_unf <= $random(seed);
         fcc_unf <= $random(seed);
         rm_flt <= $random(seed);
         fcc_flt <= $random(seed);
         repeat (2) @(posedge pclk);
         #1;
         chk(rm_out, i ? rm_flt : rm_unf);
         chk(full_charge_capacity, i ? fcc_flt : fcc_unf);
         chk(soc_out, soc_exp(i ? rm_flt : rm_unf, i ? fcc_flt : fcc_unf));
      end
      for (i = 0; i < 10; i++) begin
         @(posedge pclk);
         qmax_old <= 16'd2000 + 16'({$random(seed)} % 4000);
         @(posedge pclk);
         qmax_new <= (i == 0) ? qmax_old + 16'd601 : qmax_old + 16'({$random(seed)} % 2400) - 16'd1200;
         qmax_valid <= 1'b1;
         @(posedge pclk);
         qmax_valid <= 1'b0;
         #1;
         chk({qmax_out_valid, qmax_out}, {1'b1, qclamp(qmax_old, qmax_new)});
      end
      dsg_active <= 1'b1;
      sample_and_count(2);
      sample_and_count(2);
      dsg_active <= 1'b0;
      repeat (2) @(posedge pclk);
      rw(0, `GLL_OFS_AVG_I, 0);
      chk(rd, 32'd100);
      rw(0, `GLL_OFS_AVG_P, 0);
      chk(rd, 32'd100000);
      finish_test();
   end
endmodule : gll_gauge_log_test
